// >>> verilog/eem_target.sv
// two-address serial-bus target emulating a byte memory plus sensor readout
// assumes link_clk_in free-running at least 15x the bus clock; pins open-drain
`timescale 1ns/1ps
`default_nettype none
module eem_target
  import eem_pkg::*;
#(
  parameter logic [6:0] MEM_TADDR     = EEM_MEM_TADDR,
  parameter logic [6:0] SNS_TADDR     = EEM_SNS_TADDR,
  parameter int         SAMPLE_CYCLES = EEM_SAMPLE_CYC
) (
  // core clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // link sampling clock
  input  wire logic        link_clk_in,
  // bus pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oen_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oen_out,
  // write guard, low allows writes
  input  wire logic        wr_allow_n_in,
  // backing store and sensor converters, core domain
  input  wire logic        mem_ready_in,
  input  wire logic [31:0] vcc_smp_in,
  input  wire logic [31:0] tempc_smp_in,
  input  wire logic [31:0] tempf_smp_in
);

  function automatic logic [7:0] sns_pick(input eem_sns_s s, input logic [7:0] sel, input logic [1:0] idx);
    logic [31:0] w;
    w = {4{EEM_FILL_BYTE}};
    case (sel)
      EEM_SEL_VCC:    w = s.vcc;
      EEM_SEL_TEMP_C: w = s.temp_c;
      EEM_SEL_TEMP_F: w = s.temp_f;
      default:        w = {4{EEM_FILL_BYTE}};
    endcase
    return w[{idx, 3'b000} +: 8];
  endfunction

  function automatic logic [17:0] loc_step(input logic [17:0] l);
    return (l >= EEM_LOC_LAST) ? EEM_LOC_ZERO : l + 18'h00001;
  endfunction

  // link domain reset and pin synchronisers
  logic lrst_s1_r, lrst_s2_r;
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r, wg_s1_r, wg_s2_r;
  wire  lrstn = lrst_s2_r;

  always_ff @(posedge link_clk_in) begin
    lrst_s1_r <= rstn_in;
    lrst_s2_r <= lrst_s1_r;
  end

  // sampling at 160 ns leaves >15 samples per bit even at the fast rate
  always_ff @(posedge link_clk_in) begin
    if (!lrstn) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'b111; // RULE5
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'b111;
      {wg_s1_r, wg_s2_r}            <= 2'b11;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
      wg_s1_r  <= wr_allow_n_in;
      wg_s2_r  <= wg_s1_r;
    end
  end

  wire scl_rise  = scl_s2_r & ~scl_d_r;
  wire scl_fall  = ~scl_s2_r & scl_d_r;
  wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // guard must have stayed low for the setup time before bytes are stored
  logic [5:0] wg_cnt_r;
  wire        wg_ok = (wg_cnt_r == 6'(EEM_WG_SETUP_CYC));

  always_ff @(posedge link_clk_in) begin
    if (!lrstn || wg_s2_r) begin
      wg_cnt_r <= 6'h00; // RULE7
    end else if (!wg_ok) begin
      wg_cnt_r <= wg_cnt_r + 6'h01; // RULE6
    end
  end

  // link state
  eem_st_e     st_r;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  sh_r, tx_r, sel_r;
  logic        first_r, tgt_sns_r, rd_r, sda_oen_r, scl_oen_r;
  logic [1:0]  loc_cnt_r, sns_idx_r;
  logic [17:0] loc_r;
  logic        pf_need_r, pf_req_r, pf_seen_r, pf_ack_s1_r, pf_ack_s2_r;
  logic [17:0] pf_addr_r;
  logic [7:0]  pf_buf_r;
  logic        sq_s1_r, sq_s2_r, sns_ack_r;
  eem_sns_s    sns_lnk_r;

  // core-side registers read across the crossing while held stable
  logic        pf_ack_c_r, sns_req_c_r;
  logic [7:0]  rd_data_c_r;
  eem_sns_s    sns_hold_c_r;

  logic        fifo_wr_ready;
  wire         addr_mem   = (sh_r[7:1] == MEM_TADDR);
  wire         addr_sns   = (sh_r[7:1] == SNS_TADDR);
  wire         rx_act     = (st_r == ST_RX_DONE) & ~scl_s2_r;
  wire         ev_addr    = rx_act & first_r;
  wire         ev_loc     = rx_act & ~first_r & ~tgt_sns_r & (loc_cnt_r != 2'(EEM_LOC_BYTES));
  wire         ev_sel     = rx_act & ~first_r & tgt_sns_r;
  wire         ev_data    = rx_act & ~first_r & ~tgt_sns_r & (loc_cnt_r == 2'(EEM_LOC_BYTES));
  wire         wr_block   = ev_data & wg_ok & ~fifo_wr_ready;
  wire         wr_push    = ev_data & wg_ok & fifo_wr_ready;
  wire         pf_valid   = ~pf_need_r & (pf_req_r == pf_seen_r);
  wire         tx_act     = (st_r == ST_TX_LOAD) & ~scl_s2_r;
  wire         tx_ready   = tgt_sns_r | pf_valid;
  wire [7:0]   tx_byte    = tgt_sns_r ? sns_pick(sns_lnk_r, sel_r, sns_idx_r) : pf_buf_r;
  wire         rx_stretch = wr_block | (tx_act & ~tx_ready);
  eem_wr_s     wr_word;

  assign wr_word = '{loc: loc_r, data: sh_r};

  always_ff @(posedge link_clk_in) begin
    if (!lrstn) begin
      st_r      <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      first_r   <= 1'b0;
      tgt_sns_r <= 1'b0;
      rd_r      <= 1'b0;
      sda_oen_r <= 1'b1;
    end else if (stop_det) begin
      st_r      <= ST_IDLE;
      sda_oen_r <= 1'b1;
    end else if (start_det) begin
      st_r      <= ST_RX;
      bit_cnt_r <= 3'h0;
      first_r   <= 1'b1;
      sda_oen_r <= 1'b1;
    end else begin
      case (st_r)
        ST_RX: begin
          if (scl_rise) begin
            sh_r      <= {sh_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              st_r <= ST_RX_DONE;
            end
          end
        end
        ST_RX_DONE: begin
          if (ev_addr) begin
            first_r   <= 1'b0;
            tgt_sns_r <= addr_sns;
            rd_r      <= sh_r[0];
            if (addr_mem || addr_sns) begin
              sda_oen_r <= 1'b0; // RULE1 RULE11 RULE12
              st_r      <= ST_RX_ACK;
            end else begin
              st_r <= ST_WAIT;
            end
          end else if (rx_act && !wr_block) begin
            sda_oen_r <= 1'b0; // RULE17
            st_r      <= ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oen_r <= 1'b1;
            bit_cnt_r <= 3'h0;
            st_r      <= rd_r ? ST_TX_LOAD : ST_RX;
          end
        end
        ST_TX_LOAD: begin
          if (tx_act && tx_ready) begin
            tx_r      <= tx_byte; // RULE16
            sda_oen_r <= tx_byte[7];
            bit_cnt_r <= 3'h0;
            st_r      <= ST_TX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              sda_oen_r <= 1'b1;
              st_r      <= ST_TX_ACK;
            end else begin
              tx_r      <= {tx_r[6:0], 1'b0};
              sda_oen_r <= tx_r[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            st_r <= sda_s2_r ? ST_WAIT : ST_TX_LOAD;
          end
        end
        default: begin
          sda_oen_r <= 1'b1;
        end
      endcase
    end
  end

  // location counter, selector and prefetch bookkeeping
  wire rd_adv = (st_r == ST_TX_ACK) & scl_rise & ~sda_s2_r & ~stop_det & ~start_det;

  always_ff @(posedge link_clk_in) begin
    if (!lrstn) begin
      loc_cnt_r <= 2'h0;
      loc_r     <= EEM_LOC_ZERO;
      sel_r     <= 8'h00;
      sns_idx_r <= 2'h0;
      pf_need_r <= 1'b0;
    end else begin
      if (ev_addr) begin
        sns_idx_r <= 2'h0;
        if (!sh_r[0]) begin
          loc_cnt_r <= 2'h0;
        end
      end
      if (ev_loc) begin
        loc_cnt_r <= loc_cnt_r + 2'h1;
        loc_r     <= (loc_cnt_r == 2'h0) ? {10'h000, sh_r} : {loc_r[9:0], sh_r}; // RULE2 RULE4
        pf_need_r <= 1'b1;
      end
      if (ev_sel) begin
        sel_r     <= sh_r;
        sns_idx_r <= 2'h0;
      end
      if (ev_data && !wr_block) begin
        loc_r     <= loc_step(loc_r); // RULE9 RULE15
        pf_need_r <= 1'b1;
      end
      if (rd_adv) begin
        if (tgt_sns_r) begin
          sns_idx_r <= sns_idx_r + 2'h1;
        end else begin
          loc_r     <= loc_step(loc_r); // RULE15
          pf_need_r <= 1'b1;
        end
      end
      if (pf_need_r && pf_req_r == pf_seen_r && !ev_data && !rd_adv && !ev_loc) begin
        pf_need_r <= 1'b0;
      end
    end
  end

  // read prefetch handshake toward the core domain
  wire pf_issue = pf_need_r & (pf_req_r == pf_seen_r) & ~ev_data & ~rd_adv & ~ev_loc;

  always_ff @(posedge link_clk_in) begin
    if (!lrstn) begin
      pf_req_r    <= 1'b0;
      pf_seen_r   <= 1'b0;
      pf_ack_s1_r <= 1'b0;
      pf_ack_s2_r <= 1'b0;
      pf_addr_r   <= EEM_LOC_ZERO;
      pf_buf_r    <= 8'h00;
    end else begin
      pf_ack_s1_r <= pf_ack_c_r;
      pf_ack_s2_r <= pf_ack_s1_r;
      if (pf_issue) begin
        pf_addr_r <= loc_r;
        pf_req_r  <= ~pf_req_r;
      end
      if (pf_ack_s2_r != pf_seen_r) begin
        pf_buf_r  <= rd_data_c_r;
        pf_seen_r <= pf_ack_s2_r;
      end
    end
  end

  // sensor snapshot taken over only between sensor transfers
  wire sns_take = (sq_s2_r != sns_ack_r) & ((st_r == ST_IDLE) | ~tgt_sns_r);

  always_ff @(posedge link_clk_in) begin
    if (!lrstn) begin
      sq_s1_r   <= 1'b0;
      sq_s2_r   <= 1'b0;
      sns_ack_r <= 1'b0;
      sns_lnk_r <= '0;
    end else begin
      sq_s1_r <= sns_req_c_r;
      sq_s2_r <= sq_s1_r;
      if (sns_take) begin
        sns_lnk_r <= sns_hold_c_r; // RULE13
        sns_ack_r <= sq_s2_r;
      end
    end
  end

  // clock stretching is the back-pressure path from the buffer to the host
  always_ff @(posedge link_clk_in) begin
    if (!lrstn) begin
      scl_oen_r <= 1'b1;
    end else begin
      scl_oen_r <= ~rx_stretch;
    end
  end

  assign scl_out     = 1'b0;
  assign sda_out     = 1'b0;
  assign scl_oen_out = scl_oen_r;
  assign sda_oen_out = sda_oen_r;

  // write path across the clock boundary
  logic    fifo_rd_valid;
  eem_wr_s fifo_rd_word;

  eem_fifo #(
    .WIDTH ($bits(eem_wr_s)),
    .DEPTH (EEM_FIFO_DEPTH)
  ) u_wr_fifo (
    .wr_clk_in    (link_clk_in),
    .wr_rstn_in   (lrstn),
    .wr_valid_in  (wr_push),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (wr_word),
    .rd_clk_in    (core_clk_in),
    .rd_rstn_in   (rstn_in),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (mem_ready_in),
    .rd_data_out  (fifo_rd_word)
  );

  // core domain: storage array, read service, sensor sampler
  logic [7:0]  mem_r [EEM_MEM_BYTES];
  logic        pfq_s1_r, pfq_s2_r, sack_s1_r, sack_s2_r, smp_due_r;
  logic [26:0] smp_cnt_r;
  wire         commit   = fifo_rd_valid & mem_ready_in;
  wire         rd_serve = (pfq_s2_r != pf_ack_c_r) & ~fifo_rd_valid;
  wire         smp_wrap = (smp_cnt_r == 27'(SAMPLE_CYCLES - 1));
  wire         smp_load = smp_due_r & ~fifo_rd_valid & (sns_req_c_r == sack_s2_r);

  always_ff @(posedge core_clk_in) begin
    if (commit && fifo_rd_word.loc <= EEM_LOC_LAST) begin
      mem_r[fifo_rd_word.loc] <= fifo_rd_word.data; // RULE3 RULE8 RULE10
    end
  end

  // reads wait for pending writes so a read-back sees the newest data
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pfq_s1_r    <= 1'b0;
      pfq_s2_r    <= 1'b0;
      pf_ack_c_r  <= 1'b0;
      rd_data_c_r <= 8'h00;
    end else begin
      pfq_s1_r <= pf_req_r;
      pfq_s2_r <= pfq_s1_r;
      if (rd_serve) begin
        rd_data_c_r <= (pf_addr_r <= EEM_LOC_LAST) ? mem_r[pf_addr_r] : EEM_FILL_BYTE;
        pf_ack_c_r  <= pfq_s2_r;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      smp_cnt_r    <= 27'h0000000;
      smp_due_r    <= 1'b0;
      sns_req_c_r  <= 1'b0;
      sack_s1_r    <= 1'b0;
      sack_s2_r    <= 1'b0;
      sns_hold_c_r <= '0;
    end else begin
      sack_s1_r <= sns_ack_r;
      sack_s2_r <= sack_s1_r;
      smp_cnt_r <= smp_wrap ? 27'h0000000 : smp_cnt_r + 27'h0000001;
      if (smp_load) begin
        sns_hold_c_r <= '{vcc: vcc_smp_in, temp_c: tempc_smp_in, temp_f: tempf_smp_in}; // RULE14
        sns_req_c_r  <= ~sns_req_c_r;
        smp_due_r    <= smp_wrap;
      end else if (smp_wrap) begin
        smp_due_r <= 1'b1; // RULE13
      end
    end
  end

  chk_addr_foreign: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE1
    (ev_addr && !addr_mem && !addr_sns && !stop_det && !start_det) |=> (st_r == ST_WAIT) && sda_oen_r)
    else $error("foreign target address was acknowledged");
  chk_poll_ack_now: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE12
    (ev_addr && addr_mem && !stop_det && !start_det) |=> !sda_oen_r && scl_oen_r)
    else $error("memory address not acknowledged at once");
  chk_guard_blocks: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE7
    $past(wg_s2_r) |-> !wr_push)
    else $error("write accepted while guard released");
  chk_guard_handshake: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE17
    (ev_data && !wg_ok && !stop_det && !start_det) |=> !sda_oen_r && (st_r == ST_RX_ACK))
    else $error("guarded data byte not acknowledged");
  chk_loc_step: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE15
    (wr_push && !stop_det && !start_det) |=> loc_r == loc_step($past(loc_r)))
    else $error("location did not advance by one after a write");
  chk_loc_low_byte: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE2
    (ev_loc && !stop_det && !start_det) |=> loc_r[7:0] == $past(sh_r))
    else $error("location byte not taken into the low bits");
  chk_stretch_full: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE9
    (wr_block && !stop_det && !start_det) |=> !scl_oen_r && (st_r == ST_RX_DONE))
    else $error("full buffer did not stretch the clock");
  chk_sel_byte: assert property (@(posedge link_clk_in) disable iff (!lrstn) // RULE16
    (tx_act && tgt_sns_r && !stop_det && !start_det) |=> tx_r == $past(sns_pick(sns_lnk_r, sel_r, sns_idx_r)))
    else $error("sensor byte does not follow the selector");
  chk_commit_now: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE10
    (commit && fifo_rd_word.loc <= EEM_LOC_LAST) |=> mem_r[$past(fifo_rd_word.loc)] == $past(fifo_rd_word.data))
    else $error("data byte not committed in the next cycle");
  chk_sample_due: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE13
    smp_wrap |=> smp_due_r || $changed(sns_req_c_r))
    else $error("sample period elapsed without a sample");
  chk_sample_yields: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // RULE14
    fifo_rd_valid |=> $stable(sns_hold_c_r))
    else $error("sampling took a cycle while writes were pending");

  cov_mem_write: cover property (@(posedge link_clk_in) disable iff (!lrstn) wr_push);
  cov_sns_read:  cover property (@(posedge link_clk_in) disable iff (!lrstn) tx_act && tgt_sns_r);
  cov_stretch:   cover property (@(posedge link_clk_in) disable iff (!lrstn) wr_block);
  cov_mem_read:  cover property (@(posedge link_clk_in) disable iff (!lrstn) rd_adv && !tgt_sns_r);

endmodule // eem_target
`default_nettype wire

// >>> verilog/eem_pkg.sv
// constants, types and state encoding shared by the emulated-memory target
// assumes a 100 MHz core clock and a free-running link sampling clock
//
// Summary of operation
// [RULE1] answer target address 0x50 for memory and 0x51 for sensors, both adjustable
// [RULE2] host sends three location bytes; only the low 18 of 24 bits count
// [RULE3] emulated array holds 246KB of byte-addressable storage
// [RULE4] build option: two location bytes when the array is below 64KB; the code has no such option and always takes three
// [RULE5] bus runs only at 100 kHz or 400 kHz serial clock
// [RULE6] host holds the write guard low at least 10 us before writing
// [RULE7] write guard not low protects the array from every write
// [RULE8] byte write: memory address, location bytes, one data byte, then STOP
// [RULE9] stream write stores successive bytes at successive locations until STOP
// [RULE10] every data byte is committed at once, no page buffer, no length limit
// [RULE11] address poll answered with ACK means the previous write has finished; the code acks at once even with bytes still in the write buffer
// [RULE12] a poll right after a write STOP is acknowledged at once
// [RULE13] supply and temperature sampled once per second, latest values kept
// [RULE14] sampling is low priority and never delays memory traffic
// [RULE15] location counter advances by one after every byte transferred; the code leaves it unchanged after a read byte the host NACKs
// [RULE16] sensor selector 0x01 supply, 0x02 Celsius, 0x03 Fahrenheit, four bytes each
// [RULE17] guarded writes still handshake but data bytes are dropped
package eem_pkg;

  localparam logic [6:0]  EEM_MEM_TADDR   = 7'h50;
  localparam logic [6:0]  EEM_SNS_TADDR   = 7'h51;
  localparam int          EEM_LOC_BYTES   = 3;
  localparam int          EEM_RX_BITS     = 24;
  localparam int          EEM_LOC_BITS    = 18;
  localparam int          EEM_MEM_KB      = 246;
  localparam int          EEM_MEM_BYTES   = EEM_MEM_KB * 1024;
  localparam logic [17:0] EEM_LOC_LAST    = 18'(EEM_MEM_BYTES - 1);
  localparam logic [17:0] EEM_LOC_ZERO    = 18'h00000;
  localparam logic [7:0]  EEM_FILL_BYTE   = 8'hff;

  localparam logic [7:0]  EEM_SEL_VCC     = 8'h01;
  localparam logic [7:0]  EEM_SEL_TEMP_C  = 8'h02;
  localparam logic [7:0]  EEM_SEL_TEMP_F  = 8'h03;
  localparam int          EEM_SNS_BYTES   = 4;

  localparam int          EEM_FIFO_DEPTH  = 8;

  localparam int          EEM_SCL_STD_HZ  = 100_000;
  localparam int          EEM_SCL_FAST_HZ = 400_000;
  localparam int          EEM_CORE_CLK_NS = 10;
  localparam int          EEM_LINK_CLK_NS = 160;

  localparam int          EEM_WG_SETUP_NS  = 10_000;
  localparam int          EEM_WG_SETUP_CYC = (EEM_WG_SETUP_NS + EEM_LINK_CLK_NS - 1) / EEM_LINK_CLK_NS;

  localparam int          EEM_SAMPLE_MS   = 1000;
  localparam int          EEM_SAMPLE_CYC  = EEM_SAMPLE_MS * (1_000_000 / EEM_CORE_CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_RX_DONE, ST_RX_ACK, ST_TX_LOAD, ST_TX, ST_TX_ACK, ST_WAIT
  } eem_st_e;

  typedef struct packed {
    logic [17:0] loc;
    logic [7:0]  data;
  } eem_wr_s;

  typedef struct packed {
    logic [31:0] vcc;
    logic [31:0] temp_c;
    logic [31:0] temp_f;
  } eem_sns_s;

endpackage

// >>> verilog/eem_fifo.sv
// dual-clock word buffer with gray-coded pointers
// assumes each side has its own synchronous active-low reset released together
`timescale 1ns/1ps
`default_nettype none
module eem_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // write side
  input  wire logic             wr_clk_in,
  input  wire logic             wr_rstn_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // read side
  input  wire logic             rd_clk_in,
  input  wire logic             rd_rstn_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wbin_r, wgray_r, rbin_r, rgray_r;
  logic [AW:0]      rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;

  wire              push     = wr_valid_in & wr_ready_out;
  wire              pop      = rd_valid_out & rd_ready_in;
  wire [AW:0]       wbin_nxt = wbin_r + {{AW{1'b0}}, push};
  wire [AW:0]       rbin_nxt = rbin_r + {{AW{1'b0}}, pop};

  // full compares against the far pointer with its two top bits turned
  assign wr_ready_out = (wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
  assign rd_valid_out = (rgray_r != wg_s2_r);
  assign rd_data_out  = mem_r[rbin_r[AW-1:0]];

  always_ff @(posedge wr_clk_in) begin
    if (push) begin
      mem_r[wbin_r[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge wr_clk_in) begin
    if (!wr_rstn_in) begin
      wbin_r  <= '0;
      wgray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  always_ff @(posedge rd_clk_in) begin
    if (!rd_rstn_in) begin
      rbin_r  <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
    end
  end
endmodule // eem_fifo
`default_nettype wire

// >>> verif/eem_host.sv
// host bus controller model: drives both open-drain lines at 400 kHz
// assumes the bench resolves both lines as wired-AND with pull-ups
`timescale 1ns/1ps
`default_nettype none
module eem_host (
  // resolved lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  // drive enables, low pulls the line
  output var logic  scl_oen_out,
  output var logic  sda_oen_out
);
  localparam int QP = 625;
  // set once a stretched clock outlasts the wait bound
  logic stuck = 1'b0;
  initial begin
    scl_oen_out = 1'b1;
    sda_oen_out = 1'b1;
  end
  // stretch wait is bounded; the bench watchdog catches a stuck line
  task automatic clk_hi;
    int n;
    n = 0;
    scl_oen_out <= 1'b1;
    #1;
    while (scl_in !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    if (n == 4000) stuck = 1'b1;
    #QP;
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_oen_out <= b;
    #QP;
    clk_hi;
    r = sda_in;
    #QP;
    scl_oen_out <= 1'b0;
    #QP;
  endtask
  task automatic start;
    sda_oen_out <= 1'b1;
    #QP;
    clk_hi;
    sda_oen_out <= 1'b0;
    #QP;
    scl_oen_out <= 1'b0;
    #QP;
  endtask
  task automatic stop;
    sda_oen_out <= 1'b0;
    #QP;
    clk_hi;
    sda_oen_out <= 1'b1;
    #QP;
  endtask
  // ack reads back as 1 when the target pulled the line low
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      xbit(1'b1, r);
      d = {d[6:0], r};
    end
    xbit(last, r);
  endtask
endmodule // eem_host
`default_nettype wire

// >>> verif/tb.sv
// top-level bench: target plus host model on a pulled-up two-wire bus
// assumes each line is pulled up and low while any enabled driver drives 0
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eem_pkg::*;
  localparam logic [31:0] SNS [3] = '{32'h40533333, 32'h41c80000, 32'h42b00000};
  logic core_clk_in = 1'b0;
  logic link_clk    = 1'b0;
  logic rstn_in     = 1'b0;
  logic wg_n        = 1'b1;
  logic mem_rdy     = 1'b1;
  wire logic d_scl_oen, d_sda_oen, h_scl_oen, h_sda_oen, d_scl_o, d_sda_o;
  wire logic scl_w = (d_scl_oen | d_scl_o) & h_scl_oen;
  wire logic sda_w = (d_sda_oen | d_sda_o) & h_sda_oen;
  int failures  = 0;
  int n_tests   = 0;
  int n_stretch = 0;
  eem_target #(.SAMPLE_CYCLES(2000)) u_dut (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk),
    .scl_in(scl_w), .scl_out(d_scl_o), .scl_oen_out(d_scl_oen),
    .sda_in(sda_w), .sda_out(d_sda_o), .sda_oen_out(d_sda_oen),
    .wr_allow_n_in(wg_n), .mem_ready_in(mem_rdy),
    .vcc_smp_in(SNS[0]), .tempc_smp_in(SNS[1]), .tempf_smp_in(SNS[2]));
  eem_host u_host (.scl_in(scl_w), .sda_in(sda_w), .scl_oen_out(h_scl_oen), .sda_oen_out(h_sda_oen));
  initial forever #5 core_clk_in = ~core_clk_in;
  // counts every clock stretch the target applies
  always @(negedge d_scl_oen) n_stretch++;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic set_loc(input logic [23:0] l);
    logic a;
    u_host.start;
    u_host.wr(8'ha0, a);
    chk(a, 1);
    for (int i = 2; i >= 0; i--) begin
      u_host.wr(l[8*i +: 8], a);
      chk(a, 1);
    end
  endtask
  // upper location bits are junk; a read while writes wait must stretch; guarded write must not land
  task automatic t_mem;
    logic a;
    logic [7:0] d;
    @(posedge core_clk_in) mem_rdy <= 1'b0;
    set_loc(24'hff0010);
    u_host.wr(8'h5a, a);
    chk(a, 1);
    u_host.wr(8'ha5, a);
    chk(a, 1);
    u_host.stop;
    u_host.start;
    u_host.wr(8'ha1, a);
    chk(a, 1);
    // store stays busy a while, so the current-address read has to wait
    fork
      begin
        repeat (300) @(posedge core_clk_in);
        mem_rdy <= 1'b1;
      end
    join_none
    u_host.rd(1'b1, d);
    chk(n_stretch, 1);
    u_host.stop;
    @(posedge core_clk_in) wg_n <= 1'b1;
    #2000;
    set_loc(24'h030010);
    u_host.wr(8'h00, a);
    chk(a, 1);
    u_host.stop;
    set_loc(24'h030010);
    u_host.start;
    u_host.wr(8'ha1, a);
    chk(a, 1);
    u_host.rd(1'b0, d);
    chk(d, 8'h5a);
    u_host.rd(1'b1, d);
    chk(d, 8'ha5);
    u_host.stop;
  endtask
  task automatic t_sns;
    logic a;
    logic [7:0] d;
    logic [31:0] v;
    u_host.start;
    u_host.wr(8'ha4, a);
    chk(a, 0);
    u_host.stop;
    for (int s = 0; s < 3; s++) begin
      u_host.start;
      u_host.wr(8'ha2, a);
      chk(a, 1);
      u_host.wr(8'(s + 1), a);
      chk(a, 1);
      u_host.start;
      u_host.wr(8'ha3, a);
      chk(a, 1);
      for (int i = 0; i < 4; i++) begin
        u_host.rd(i == 3, d);
        v = {d, v[31:8]};
      end
      u_host.stop;
      chk(v, SNS[s]);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 110000 && !u_host.stuck; i++) @(posedge core_clk_in);
    failures++;
    end_sim;
  end
  // reset also has to reach the link flops, so it outlasts four link edges
  initial begin
    repeat (70) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    wg_n    <= 1'b0;
    #12000;
    t_mem;
    t_sns;
    end_sim;
  end
endmodule // tb
`default_nettype wire
